/* File: src/ccc_pkg.sv */
package ccc_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADR_CMD_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_CLK_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_TX_DELAY = 8'h0C;

  // Field positions
  localparam int CMD_LSB        = 0;
  localparam int CMD_W          = 3;
  localparam int START_SEND_BIT = 3;
  localparam int CLK_SEL_LSB    = 0;
  localparam int CLK_SEL_W      = 2;
  localparam int RELEASE_BIT    = 2;
  localparam int SYNTH_BIT      = 4;
  localparam int FALLBACK_BIT   = 5;
  localparam int ST_TXACT_BIT   = 4;
  localparam int ST_RXEN_BIT    = 5;
  localparam int ST_CLKERR_BIT  = 15;
  localparam int DELAY_W        = 16;

  // Clock stand-in dividers (half periods in ref_clk cycles)
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] PLL_HALF_CYC = 4'h4;
  localparam logic [DIV_W-1:0] TMP_HALF_CYC = 4'h8;

  // Command codes
  typedef enum logic [2:0] {
    HALT_CMD      = 3'b000,
    TX_CMD        = 3'b001,
    RX_CMD        = 3'b010,
    TRX_CMD       = 3'b011,
    HOLD_CMD      = 3'b100,
    SELF_ECHO_CMD = 3'b101,
    PRBS_CMD      = 3'b110,
    RSVD_CMD      = 3'b111
  } ccc_cmd_t;

  // Clock source selection and actual source
  typedef enum logic [1:0] {
    SRC_AUTO = 2'b00,
    SRC_RF   = 2'b01,
    SRC_PLL  = 2'b10,
    SRC_TEMP = 2'b11
  } ccc_src_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_TX   = 3'b010,
    ST_RX   = 3'b011,
    ST_ECHO = 3'b100,
    ST_PRBS = 3'b101,
    ST_ARM  = 3'b110
  } ccc_fsm_t;

  // Register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ccc_bus_t;

  // Whole state of the block
  typedef struct packed {
    logic               fld_s1;
    logic               fld_s2;
    logic               fld_q;
    logic               lnk_s1;
    logic               lnk_s2;
    logic               busy_q;
    ccc_cmd_t           cmd;
    logic               start_send;
    ccc_src_t           clk_sel;
    logic               fallback;
    logic               synth;
    logic [DELAY_W-1:0] delay;
    logic [DELAY_W-1:0] wait_cnt;
    ccc_fsm_t           fsm;
    logic               tx_pulse;
    logic               rx_en;
    logic               prbs;
    logic               temp_latched;
    ccc_src_t           cur_src;
    logic               fe_clk;
    logic [DIV_W-1:0]   pll_cnt;
    logic               pll_lvl;
    logic [DIV_W-1:0]   tmp_cnt;
    logic               tmp_lvl;
    logic [DATA_W-1:0]  rdata;
  } ccc_state_t;

  localparam ccc_state_t STATE_RST = '0;

endpackage

/* File: src/ccc_cmd_clk_ctrl.sv */
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ccc_cmd_clk_ctrl
  import ccc_pkg::*;
(
  input  wire logic              ref_clk_i,    // System clock
  input  wire logic              nrst_i,       // Async reset, active low
  input  wire ccc_bus_t          bus_i,        // Register request
  output var  logic [DATA_W-1:0] rdata_o,      // Read data, one cycle later
  input  wire logic              field_det_i,  // External field present, async
  input  wire logic              link_clk_i,   // Received field clock, async
  input  wire logic              initiator_i,  // Poll-side role setting
  input  wire logic              tx_busy_i,    // Encoder sending
  input  wire logic              rx_done_i,    // Reception ended, one pulse
  output logic                   tx_start_o,   // Start encoder, one pulse
  output logic                   rx_en_o,      // Receiver enabled
  output logic                   prbs_o,       // Encoder sends test stream
  output logic [1:0]             clk_src_o,    // Source in use
  output logic                   fe_clk_o      // Front-end clock
);

  ccc_state_t s;       // Registered state
  ccc_state_t next_s;  // Next state
  logic       wr_cmd;  // Write to command register
  logic       wr_clk;  // Write to clock register
  ccc_cmd_t   new_cmd; // Command field of a write
  ccc_src_t   want;    // Source the selector asks for
  logic       fld_fall; // Field just lost
  logic       tx_fall;  // Encoder just went idle
  logic [3:0] lvl;      // Level of each source

  // Decode bus writes
  assign wr_cmd  = bus_i.wr && (bus_i.addr == ADR_CMD_CTRL);
  assign wr_clk  = bus_i.wr && (bus_i.addr == ADR_CLK_CTRL);
  assign new_cmd = ccc_cmd_t'(bus_i.wdata[CMD_LSB +: CMD_W]);
  assign fld_fall = s.fld_q && !s.fld_s2;
  assign tx_fall  = s.busy_q && !tx_busy_i;

  // Level of every candidate source
  always_comb begin
    lvl = 4'h0;
    lvl[SRC_RF]   = s.lnk_s2;
    lvl[SRC_PLL]  = s.pll_lvl;
    lvl[SRC_TEMP] = s.tmp_lvl;
  end

  // Source wanted by the selector
  always_comb begin
    case (s.clk_sel)
      SRC_RF:   want = SRC_RF;
      SRC_PLL:  want = SRC_PLL;
      SRC_TEMP: want = SRC_TEMP;
      default: begin
        if (s.temp_latched) begin
          want = SRC_TEMP;
        end else if (s.synth && tx_busy_i) begin
          want = SRC_PLL;
        end else if (s.fld_s2) begin
          want = SRC_RF;
        end else begin
          want = SRC_PLL;
        end
      end
    endcase
  end

  // Next state
  always_comb begin
    next_s = s;
    // Synchronisers and edge history
    next_s.fld_s1 = field_det_i;
    next_s.fld_s2 = s.fld_s1;
    next_s.fld_q  = s.fld_s2;
    next_s.lnk_s1 = link_clk_i;
    next_s.lnk_s2 = s.lnk_s1;
    next_s.busy_q = tx_busy_i;
    next_s.tx_pulse = 1'b0;

    // Sequencer
    case (s.fsm)
      ST_TX: begin
        if (tx_fall) begin
          if (s.cmd == TRX_CMD) begin
            next_s.fsm = ST_RX;
          end else begin
            next_s.fsm = ST_IDLE;
            next_s.cmd = HALT_CMD;
          end
        end
      end
      ST_RX: begin
        if (rx_done_i) begin
          if (s.cmd == TRX_CMD) begin
            next_s.fsm = ST_ARM;
          end else begin
            next_s.fsm = ST_IDLE;
            next_s.cmd = HALT_CMD;
          end
        end
      end
      ST_ARM: begin
        if (s.start_send) begin
          next_s.wait_cnt = s.delay;
          next_s.fsm = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (s.wait_cnt == '0) begin
          next_s.tx_pulse   = 1'b1;
          next_s.start_send = 1'b0;
          next_s.fsm        = ST_TX;
        end else begin
          next_s.wait_cnt = s.wait_cnt - 16'h0001;
        end
      end
      ST_ECHO: next_s.fsm = ST_ECHO;
      ST_PRBS: next_s.fsm = ST_PRBS;
      ST_IDLE: next_s.fsm = ST_IDLE;
      default: next_s.fsm = ST_IDLE;
    endcase

    // Command register write; a new command restarts the sequencer
    if (wr_cmd) begin
      case (new_cmd)
        HALT_CMD: begin
          next_s.cmd        = HALT_CMD;
          next_s.fsm        = ST_IDLE;
          next_s.start_send = 1'b0;
          next_s.tx_pulse   = 1'b0;
        end
        TX_CMD: begin
          next_s.cmd      = TX_CMD;
          next_s.fsm      = ST_TX;
          next_s.tx_pulse = 1'b1;
        end
        RX_CMD: begin
          next_s.cmd = RX_CMD;
          next_s.fsm = ST_RX;
        end
        TRX_CMD: begin
          next_s.cmd = TRX_CMD;
          next_s.fsm = initiator_i ? ST_ARM : ST_RX;
        end
        SELF_ECHO_CMD: begin
          next_s.cmd      = SELF_ECHO_CMD;
          next_s.fsm      = ST_ECHO;
          next_s.tx_pulse = 1'b1;
        end
        PRBS_CMD: begin
          next_s.cmd      = PRBS_CMD;
          next_s.fsm      = ST_PRBS;
          next_s.tx_pulse = 1'b1;
        end
        default: begin
          // Keep or reserved code: command stays as it is
          next_s.cmd = s.cmd;
        end
      endcase
      // Start-send set wins over the hardware clear
      if (bus_i.wdata[START_SEND_BIT] && (next_s.cmd == TRX_CMD)) begin
        next_s.start_send = 1'b1;
      end
    end

    // Receiver and test stream follow the sequencer state
    next_s.rx_en = (next_s.fsm == ST_RX) || (next_s.fsm == ST_ECHO);
    next_s.prbs  = (next_s.fsm == ST_PRBS);

    // Clock control and delay writes
    if (wr_clk) begin
      next_s.clk_sel  = ccc_src_t'(bus_i.wdata[CLK_SEL_LSB +: CLK_SEL_W]);
      next_s.synth    = bus_i.wdata[SYNTH_BIT];
      next_s.fallback = bus_i.wdata[FALLBACK_BIT];
      if (bus_i.wdata[RELEASE_BIT]) begin
        next_s.temp_latched = 1'b0;
      end
    end
    if (bus_i.wr && (bus_i.addr == ADR_TX_DELAY)) begin
      next_s.delay = bus_i.wdata[DELAY_W-1:0];
    end
    // Field loss latches the temporary clock; set wins over release
    if (fld_fall && s.fallback && (s.clk_sel == SRC_AUTO)) begin
      next_s.temp_latched = 1'b1;
    end

    // Stand-in dividers for synthesized and temporary clocks
    if (s.pll_cnt == PLL_HALF_CYC - 4'h1) begin
      next_s.pll_cnt = '0;
      next_s.pll_lvl = !s.pll_lvl;
    end else begin
      next_s.pll_cnt = s.pll_cnt + 4'h1;
    end
    if (s.tmp_cnt == TMP_HALF_CYC - 4'h1) begin
      next_s.tmp_cnt = '0;
      next_s.tmp_lvl = !s.tmp_lvl;
    end else begin
      next_s.tmp_cnt = s.tmp_cnt + 4'h1;
    end

    // Switch only while output and new source are both low
    if ((want != s.cur_src) && !s.fe_clk && !lvl[want]) begin
      next_s.cur_src = want;
    end
    next_s.fe_clk = lvl[next_s.cur_src];

    // Read data, one cycle after the strobe
    next_s.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADR_CMD_CTRL: begin
          next_s.rdata[CMD_LSB +: CMD_W] = s.cmd;
          next_s.rdata[START_SEND_BIT]   = s.start_send;
        end
        ADR_CLK_CTRL: begin
          next_s.rdata[CLK_SEL_LSB +: CLK_SEL_W] = s.clk_sel;
          next_s.rdata[SYNTH_BIT]    = s.synth;
          next_s.rdata[FALLBACK_BIT] = s.fallback;
        end
        ADR_STATUS: begin
          next_s.rdata[ST_CLKERR_BIT] = (s.cur_src == SRC_TEMP);
          next_s.rdata[ST_TXACT_BIT]  = tx_busy_i;
          next_s.rdata[ST_RXEN_BIT]   = s.rx_en;
        end
        ADR_TX_DELAY: begin
          next_s.rdata[DELAY_W-1:0] = s.delay;
        end
        default: next_s.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign rdata_o    = s.rdata;
  assign tx_start_o = s.tx_pulse;
  assign rx_en_o    = s.rx_en;
  assign prbs_o     = s.prbs;
  assign clk_src_o  = s.cur_src;
  assign fe_clk_o   = s.fe_clk;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_HALT_IDLE: assert property (
    wr_cmd && new_cmd == HALT_CMD |=> s.fsm == ST_IDLE && !rx_en_o && !s.start_send)
    else $error("halt did not return to idle");
  AST_TX_NOW: assert property (
    wr_cmd && new_cmd == TX_CMD |=> tx_start_o && s.fsm == ST_TX)
    else $error("transmit command did not start at once");
  AST_RX_CLEAR: assert property (
    s.fsm == ST_RX && s.cmd == RX_CMD && rx_done_i && !wr_cmd
      |=> s.cmd == HALT_CMD && !rx_en_o)
    else $error("receive did not clear to idle");
  AST_TRX_ROLE: assert property (
    wr_cmd && new_cmd == TRX_CMD |=> s.fsm == ($past(initiator_i) ? ST_ARM : ST_RX))
    else $error("transceive start ignores role");
  AST_TRX_STAYS: assert property (
    s.cmd == TRX_CMD && !wr_cmd |=> s.cmd == TRX_CMD)
    else $error("transceive ended by itself");
  AST_HOLD: assert property (
    wr_cmd && new_cmd == HOLD_CMD |=> s.cmd == $past(s.cmd))
    else $error("keep command altered command");
  AST_ECHO: assert property (
    wr_cmd && new_cmd == SELF_ECHO_CMD |=> tx_start_o && rx_en_o)
    else $error("self echo not both ways");
  AST_PRBS: assert property (
    prbs_o && !wr_cmd |=> prbs_o && s.cmd == PRBS_CMD)
    else $error("test stream returned by itself");
  AST_SS_GATE: assert property (
    $rose(s.start_send) |-> s.cmd == TRX_CMD)
    else $error("start-send set outside transceive");
  AST_WAIT: assert property (
    s.fsm == ST_WAIT && s.wait_cnt != '0 && !wr_cmd |=> !tx_start_o)
    else $error("transmission began before delay");
  AST_SS_CLR: assert property (
    s.fsm == ST_WAIT && s.wait_cnt == '0 && !wr_cmd |=> tx_start_o ##1 !tx_start_o)
    else $error("delayed start did not pulse once");
  AST_SS_DROP: assert property (
    s.fsm == ST_WAIT && s.wait_cnt == '0 && !wr_cmd |=> !s.start_send)
    else $error("start-send not cleared on start");
  AST_AUTO: assert property (
    s.clk_sel == SRC_AUTO && !s.temp_latched && !(s.synth && tx_busy_i)
      |-> want == (s.fld_s2 ? SRC_RF : SRC_PLL))
    else $error("auto selection wrong");
  AST_FORCE: assert property (
    s.clk_sel != SRC_AUTO |-> want == s.clk_sel)
    else $error("forced source not taken");
  AST_FALLBACK: assert property (
    s.clk_sel == SRC_AUTO && s.fallback && fld_fall |=> s.temp_latched ##0 want == SRC_TEMP)
    else $error("field loss did not choose temporary clock");
  AST_SYNTH: assert property (
    s.clk_sel == SRC_AUTO && !s.temp_latched && s.synth && tx_busy_i |-> want == SRC_PLL)
    else $error("synth clock not used in transmit");
  AST_RELEASE: assert property (
    wr_clk && bus_i.wdata[RELEASE_BIT] && !fld_fall |=> !s.temp_latched)
    else $error("release did not free temporary clock");
  AST_STATUS: assert property (
    bus_i.rd && bus_i.addr == ADR_STATUS |=> rdata_o[ST_CLKERR_BIT] ==
      ($past(s.cur_src) == SRC_TEMP) && rdata_o[ST_TXACT_BIT] == $past(tx_busy_i))
    else $error("status bits wrong");
  AST_GLITCH: assert property (
    $changed(s.cur_src) |-> !fe_clk_o && !$past(fe_clk_o))
    else $error("source switched while clock high");

  COV_TRX_LOOP: cover property (s.fsm == ST_TX && s.cmd == TRX_CMD ##[1:200] s.fsm == ST_ARM);
  COV_DELAYED: cover property (s.fsm == ST_WAIT && s.wait_cnt != '0 ##[1:100] tx_start_o);
  COV_PRBS: cover property (wr_cmd && new_cmd == PRBS_CMD ##1 prbs_o);
  COV_TEMP: cover property (s.temp_latched ##[1:100] s.cur_src == SRC_TEMP);

endmodule
`default_nettype wire

/* File: bench/ccc_far_side.sv */
`timescale 1ns/100ps
`default_nettype none
// Stand-in for the encoder and decoder that sit beyond the block
module ccc_far_side #(
  parameter int BUSY_LEN = 6,  // Encoder busy run in cycles
  parameter int RX_LEN   = 5   // Receive cycles before end of reception
) (
  input  wire logic clk_i,      // System clock
  input  wire logic nrst_i,     // Async reset, active low
  input  wire logic tx_start_i, // Launch from the block
  input  wire logic rx_en_i,    // Receiver enable from the block
  input  wire logic rx_hold_i,  // Slow peer: keeps reception open
  output logic      tx_busy_o,  // Encoder sending
  output var logic  rx_done_o   // Reception ended, one pulse
);
  int busy_cnt;  // Remaining busy cycles
  int rx_cnt;    // Cycles spent receiving

  // Encoder: busy for a fixed run after each launch
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt <= 0;
    end else if (tx_start_i) begin
      busy_cnt <= BUSY_LEN;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end
  assign tx_busy_o = (busy_cnt > 0);

  // Decoder: one end pulse per enable period, unless held open
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_cnt    <= 0;
      rx_done_o <= 1'b0;
    end else begin
      rx_done_o <= rx_en_i && !rx_hold_i && (rx_cnt == RX_LEN);
      if (!rx_en_i) begin
        rx_cnt <= 0;
      end else if (!rx_hold_i && rx_cnt <= RX_LEN) begin
        rx_cnt <= rx_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/ccc_cmd_clk_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ccc_cmd_clk_ctrl_tb_top;
  import ccc_pkg::*;
  logic              ref_clk;    // System clock
  logic              nrst;       // Reset, active low
  ccc_bus_t          bus;        // Register request
  logic [DATA_W-1:0] rdata;      // Read data
  logic              field;      // External field present
  logic              lnk;        // Field clock, stands low without field
  logic              initiator;  // Poll-side role
  logic              tx_busy;    // Encoder busy
  logic              rx_done;    // Reception ended
  logic              rx_hold;    // Slow peer control
  logic              tx_start;   // Launch pulse
  logic              rx_en;      // Receiver enable
  logic              prbs;       // Test stream
  logic [1:0]        clk_src;    // Source in use
  logic              fe_clk;     // Front-end clock
  int                num_errors; // Mismatch count
  int                n_checks;   // Comparison count
  int                hi_run;     // High run of front-end clock

  ccc_cmd_clk_ctrl u_dut (.ref_clk_i(ref_clk), .nrst_i(nrst), .bus_i(bus), .rdata_o(rdata),
    .field_det_i(field), .link_clk_i(lnk), .initiator_i(initiator), .tx_busy_i(tx_busy),
    .rx_done_i(rx_done), .tx_start_o(tx_start), .rx_en_o(rx_en), .prbs_o(prbs),
    .clk_src_o(clk_src), .fe_clk_o(fe_clk));

  // Busy run spans a full synthesized clock period, so a switch to it can complete
  ccc_far_side #(.BUSY_LEN(12), .RX_LEN(5)) u_far (.clk_i(ref_clk), .nrst_i(nrst),
    .tx_start_i(tx_start), .rx_en_i(rx_en), .rx_hold_i(rx_hold), .tx_busy_o(tx_busy),
    .rx_done_o(rx_done));

  // System clock, 10 ns
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Field clock, 80 ns, halts low once the field is gone
  initial begin
    lnk = 1'b0;
    forever begin
      #40;
      if (field || lnk) begin
        lnk = ~lnk;
      end
    end
  end

  // Front-end clock high phases must never be shortened
  always @(posedge ref_clk) begin
    if (fe_clk === 1'b1) begin
      hi_run++;
    end else begin
      if (hi_run > 0 && hi_run < 3) begin
        num_errors++;
        $display("mismatch at %0t: high run %0h min %0h", $time, hi_run, 3);
      end
      hi_run = 0;
    end
  end

  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Register write, one cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  // Register read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus <= {1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask

  // Output picked for a bounded wait
  function automatic logic [1:0] probe(input int k);
    case (k)
      0: probe = {1'b0, tx_start};
      1: probe = {1'b0, rx_en};
      2: probe = {1'b0, tx_busy};
      3: probe = clk_src;
      default: probe = {1'b0, prbs};
    endcase
  endfunction

  // Bounded wait for an output value, n counts clock edges
  task automatic wait_for(input int k, input logic [1:0] v, output int n);
    n = 0;
    #1;
    while (probe(k) !== v && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      $display("mismatch at %0t: wait %0h for %0h", $time, k, v);
      conclude();
    end
  endtask

  // Field level change at a clock edge
  task automatic set_field(input logic v);
    @(posedge ref_clk);
    field <= v;
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    int n;
    nrst = 1'b0; bus = '0; field = 1'b0; initiator = 1'b1; rx_hold = 1'b0;
    num_errors = 0; n_checks = 0; hi_run = 0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADR_CMD_CTRL, 32'h0000_0000);
    rd(ADR_CLK_CTRL, 32'h0000_0000);
    wait_for(3, 2'h2, n);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0000);
    $display("test reset done");
    // Transmit starts at once and clears when the encoder idles
    wr(ADR_CMD_CTRL, 32'h0000_0001);
    wait_for(0, 2'h1, n); chk(32'(n), 32'h0);
    rd(ADR_STATUS, 32'h0000_0010);
    wait_for(2, 2'h0, n);
    rd(ADR_STATUS, 32'h0000_0000);
    rd(ADR_CMD_CTRL, 32'h0000_0000);
    $display("test transmit done");
    // Receive, start-send ignored, clears after reception
    rx_hold <= 1'b1;
    wr(ADR_CMD_CTRL, 32'h0000_000A);
    wait_for(1, 2'h1, n); chk(32'(tx_start), 32'h0);
    rd(ADR_CMD_CTRL, 32'h0000_0002);
    rd(ADR_STATUS, 32'h0000_0020);
    @(posedge ref_clk);
    rx_hold <= 1'b0;
    wait_for(1, 2'h0, n);
    rd(ADR_CMD_CTRL, 32'h0000_0000);
    $display("test receive done");
    // Transceive with no delay and with delay 5, cycling once each
    for (int i = 0; i < 2; i++) begin
      wr(ADR_TX_DELAY, 32'(i * 5));
      rd(ADR_TX_DELAY, 32'(i * 5));
      wr(ADR_CMD_CTRL, 32'h0000_000B);
      wait_for(0, 2'h1, n); chk(32'(n), 32'(i * 5 + 2));
      rd(ADR_CMD_CTRL, 32'h0000_0003);
      wait_for(1, 2'h1, n);
      wait_for(1, 2'h0, n);
      rd(ADR_CMD_CTRL, 32'h0000_0003);
    end
    // Keep command with start-send launches again under transceive
    wr(ADR_CMD_CTRL, 32'h0000_000C);
    wait_for(0, 2'h1, n);
    rd(ADR_CMD_CTRL, 32'h0000_0003);
    rx_hold <= 1'b1;
    wait_for(1, 2'h1, n);
    wr(ADR_CMD_CTRL, 32'h0000_0000);
    wait_for(1, 2'h0, n); chk(32'(n > 2), 32'h0);
    rd(ADR_CMD_CTRL, 32'h0000_0000);
    // Responder role begins with reception
    initiator <= 1'b0;
    wr(ADR_CMD_CTRL, 32'h0000_0003);
    wait_for(1, 2'h1, n); chk(32'(tx_start), 32'h0);
    wr(ADR_CMD_CTRL, 32'h0000_0000);
    initiator <= 1'b1;
    rx_hold <= 1'b0;
    $display("test transceive done");
    // Self echo transmits and receives together
    wr(ADR_CMD_CTRL, 32'h0000_0005);
    wait_for(0, 2'h1, n); chk(32'(n), 32'h0);
    wait_for(1, 2'h1, n); chk(32'(n > 2), 32'h0);
    wr(ADR_CMD_CTRL, 32'h0000_0000);
    // Test stream stays after the encoder idles
    wr(ADR_CMD_CTRL, 32'h0000_0006);
    wait_for(0, 2'h1, n); chk(32'(n), 32'h0);
    wait_for(4, 2'h1, n);
    wait_for(2, 2'h1, n);
    wait_for(2, 2'h0, n);
    repeat (3) @(posedge ref_clk);
    rd(ADR_CMD_CTRL, 32'h0000_0006); chk(32'(prbs), 32'h1);
    wr(ADR_CMD_CTRL, 32'h0000_0000);
    wait_for(4, 2'h0, n);
    $display("test echo and stream done");
    // Automatic and forced clock sources
    set_field(1'b1);
    wait_for(3, 2'h1, n);
    set_field(1'b0);
    wait_for(3, 2'h2, n);
    for (int s = 1; s < 4; s++) begin
      wr(ADR_CLK_CTRL, 32'(s));
      wait_for(3, 2'(s), n);
      rd(ADR_CLK_CTRL, 32'(s));
    end
    rd(ADR_STATUS, 32'h0000_8000);
    // Fallback on field loss, then release (kept to this test only)
    wr(ADR_CLK_CTRL, 32'h0000_0020);
    set_field(1'b1);
    wait_for(3, 2'h1, n);
    set_field(1'b0);
    wait_for(3, 2'h3, n);
    rd(ADR_STATUS, 32'h0000_8000);
    wr(ADR_CLK_CTRL, 32'h0000_0024);
    wait_for(3, 2'h2, n);
    rd(ADR_CLK_CTRL, 32'h0000_0020);
    rd(ADR_STATUS, 32'h0000_0000);
    // Synthesized clock while the encoder sends
    wr(ADR_CLK_CTRL, 32'h0000_0010);
    set_field(1'b1);
    wait_for(3, 2'h1, n);
    wr(ADR_CMD_CTRL, 32'h0000_0001);
    wait_for(2, 2'h1, n);
    wait_for(3, 2'h2, n);
    wait_for(2, 2'h0, n);
    wait_for(3, 2'h1, n);
    set_field(1'b0);
    $display("test clock sources done");
    conclude();
  end
endmodule
`default_nettype wire
